// ### ipm_defines.svh
// register offsets, field positions, reset values and fixed entry numbers of the positioning block
`ifndef IPM_DEFINES_SVH
`define IPM_DEFINES_SVH

`define IPM_OFS_CTRL 8'h00
`define IPM_OFS_CMD 8'h04
`define IPM_OFS_ENTRY 8'h08
`define IPM_OFS_TBL_IDX 8'h0C
`define IPM_OFS_TBL_DATA 8'h10
`define IPM_OFS_SWOFF 8'h14
`define IPM_OFS_AXIS_END 8'h18
`define IPM_OFS_STATUS 8'h1C
`define IPM_OFS_ACTUAL 8'h20
`define IPM_OFS_RESIDUAL 8'h24

`define IPM_CTRL_PARAMS_BIT 0
`define IPM_CTRL_DIMS_BIT 1
`define IPM_CTRL_ROTARY_BIT 2
`define IPM_CTRL_RELATIVE_BIT 3
`define IPM_CTRL_MODE_LSB 4
`define IPM_CTRL_MODE_MSB 5
`define IPM_CTRL_RESET 32'h0000_0000

`define IPM_CMD_START_BIT 0
`define IPM_CMD_DIRP_BIT 1
`define IPM_CMD_DIRM_BIT 2
`define IPM_CMD_STOP_BIT 3
`define IPM_CMD_DELRES_BIT 8

`define IPM_ST_BUSY_BIT 0
`define IPM_ST_DIR_BIT 1
`define IPM_ST_RESID_BIT 2
`define IPM_ST_ERROR_BIT 3
`define IPM_ST_SYNC_BIT 4
`define IPM_ST_ENABLE_BIT 5

`define IPM_MODE_INCREMENTAL 2'h1
`define IPM_ENTRY_254 8'hFE
`define IPM_ENTRY_255 8'hFF
`define IPM_ENTRY_RESET 8'h00
`define IPM_SWOFF_RESET 32'h0000_0000
`define IPM_AXIS_END_RESET 32'h0000_0168

`endif

// ### ipm_pkg.sv
// types shared by the positioning block and its helpers
package ipm_pkg;

  typedef enum logic [0:0] {
    IPM_IDLE,
    IPM_MOVE
  } ipm_state_type;

  // levels written by software into the command register
  typedef struct packed {
    logic stop;
    logic dir_m;
    logic dir_p;
    logic start;
  } ipm_cmd_type;

  // drive control lines towards the power stage
  typedef struct packed {
    logic run;
    logic dir_pos;
  } ipm_drive_type;

endpackage

// ### ipm_sync.sv
// two-stage synchroniser for level inputs from pins
`timescale 1ns/1ps
`default_nettype none
module ipm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second one
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// ### ipm_edge.sv
// rising-edge detector, one pulse per low-to-high step of each bit
`timescale 1ns/1ps
`default_nettype none
module ipm_edge #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_rise
);
  logic [WIDTH-1:0] last;

  // reset to zero so a level already high at reset gives an edge in the first cycle after reset
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last <= '0;
    end else begin
      last <= i_level;
    end
  end

  assign o_rise = i_level & ~last;
endmodule
`default_nettype wire

// ### ipm_core.sv
// incremental positioning channel: start checks, direction choice, move, residual distance
`timescale 1ns/1ps
`default_nettype none
`include "ipm_defines.svh"

// Summary of operation
// RL1: absolute targets or relative displacements from entries
// RL2: start needs params, entries, sync, valid start, enable
// RL3: controller loads entry 254 before use
// RL4: controller loads entry 255 and differences first
// RL5: controller gives displacements as positive values only
// RL6: start commands act on rising edge only
// RL7: move begins on edge with all conditions met
// RL8: relative plus moves up, minus moves down
// RL9: linear absolute direction from target versus actual
// RL10: rotary plain start takes the shorter path
// RL11: rotary plus or minus forces absolute direction
// RL12: stopped relative move keeps untravelled residual
// RL13: unchanged restart travels only the residual
// RL14: delete command clears the residual
// RL15: mode change or reversed start clears residual
// RL16: controller deletes residual before a new displacement
// RL17: start without conditions flags error, drive stays
module ipm_core #(
  parameter int W = 24,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  input wire logic i_synced,
  input wire logic i_drive_en,
  input wire logic i_enc_step,
  output ipm_pkg::ipm_drive_type o_drive
);
  import ipm_pkg::*;

  localparam int SLOTS = DEPTH + 2;
  localparam int SW = $clog2(SLOTS);

  logic [31:0] ctrl;
  ipm_cmd_type cmd;
  logic [7:0] entry;
  logic [7:0] tbl_idx;
  logic [W-1:0] swoff;
  logic [W-1:0] axis_end;
  logic [W-1:0] dim_tbl [SLOTS];
  logic [W-1:0] actual;
  logic [W-1:0] remaining;
  logic [W-1:0] residual;
  logic [7:0] res_entry;
  logic res_dir;
  logic res_valid;
  logic error;
  logic [1:0] prev_mode;
  ipm_state_type state;

  // pins cross into the core clock before use
  logic [2:0] pin_sync;
  ipm_sync #(.WIDTH(3)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async({i_enc_step, i_drive_en, i_synced}),
    .o_sync(pin_sync)
  );
  wire synced = pin_sync[0];
  wire drive_en = pin_sync[1];

  // command levels and encoder step become single-cycle events
  logic [4:0] rise;
  ipm_edge #(.WIDTH(5)) u_edge (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_level({pin_sync[2], cmd}),
    .o_rise(rise)
  );
  wire start_e = rise[0];
  wire dirp_e = rise[1];
  wire dirm_e = rise[2];
  wire stop_e = rise[3];
  wire step_e = rise[4];
  wire any_e = start_e | dirp_e | dirm_e; // [RL6]

  // register decode
  wire wr_ctrl = i_wr && (i_addr == `IPM_OFS_CTRL);
  wire wr_cmd = i_wr && (i_addr == `IPM_OFS_CMD);
  wire wr_entry = i_wr && (i_addr == `IPM_OFS_ENTRY);
  wire wr_idx = i_wr && (i_addr == `IPM_OFS_TBL_IDX);
  wire wr_data = i_wr && (i_addr == `IPM_OFS_TBL_DATA);
  wire wr_swoff = i_wr && (i_addr == `IPM_OFS_SWOFF);
  wire wr_end = i_wr && (i_addr == `IPM_OFS_AXIS_END);
  wire wr_stat = i_wr && (i_addr == `IPM_OFS_STATUS);
  wire del_res = wr_cmd && i_wr_data[`IPM_CMD_DELRES_BIT]; // [RL14]

  // control fields
  wire params_ok = ctrl[`IPM_CTRL_PARAMS_BIT];
  wire dims_ok = ctrl[`IPM_CTRL_DIMS_BIT];
  wire rotary = ctrl[`IPM_CTRL_ROTARY_BIT];
  wire relative = ctrl[`IPM_CTRL_RELATIVE_BIT];
  wire [1:0] mode = ctrl[`IPM_CTRL_MODE_MSB:`IPM_CTRL_MODE_LSB];

  // entry number to table slot; 254 and 255 take the two slots above the plain entries
  function automatic logic [SW-1:0] slot_of(input logic [7:0] num);
    logic [SW-1:0] s;
    s = SW'(DEPTH + 1);
    if (num == `IPM_ENTRY_254) begin
      s = SW'(DEPTH);
    end else if (num < 8'(DEPTH)) begin
      s = SW'(num);
    end
    return s;
  endfunction
  wire entry_ok = (entry < 8'(DEPTH)) || (entry == `IPM_ENTRY_254) || (entry == `IPM_ENTRY_255);
  wire [W-1:0] dim_val = dim_tbl[slot_of(entry)]; // [RL1]

  // start conditions; an edge of the wrong kind counts as an invalid start
  wire start_kind_ok = relative ? ((dirp_e | dirm_e) && !start_e)
                     : (rotary ? 1'b1 : (start_e && !dirp_e && !dirm_e));
  wire conds_ok = params_ok && dims_ok && synced && drive_en && entry_ok
               && (mode == `IPM_MODE_INCREMENTAL) && start_kind_ok; // [RL2]
  wire launch = (state == IPM_IDLE) && any_e && conds_ok; // [RL7]
  wire reject = (state == IPM_IDLE) && any_e && !conds_ok; // [RL17]

  // relative: direction from the command, magnitude from the entry [RL8] [RL5]
  wire rel_dir = dirp_e;
  wire resume = res_valid && (res_entry == entry) && (res_dir == rel_dir)
             && (residual > swoff); // [RL13]
  wire [W-1:0] rel_dist = resume ? residual : dim_val;

  // linear absolute: direction from target against actual position
  wire lin_up = (dim_val >= actual); // [RL9]
  wire [W-1:0] lin_dist = lin_up ? (dim_val - actual) : (actual - dim_val);

  // rotary absolute: forward span modulo the axis end, backward span is the rest
  wire [W-1:0] fwd_span = (dim_val >= actual) ? (dim_val - actual) : (dim_val + axis_end - actual);
  wire [W-1:0] bwd_span = (fwd_span == '0) ? '0 : (axis_end - fwd_span);
  wire rot_short_up = (fwd_span <= bwd_span); // [RL10]
  wire rot_up = start_e ? rot_short_up : dirp_e; // [RL11]
  wire [W-1:0] rot_dist = rot_up ? fwd_span : bwd_span;

  wire next_dir = relative ? rel_dir : (rotary ? rot_up : lin_up);
  wire [W-1:0] next_dist = relative ? rel_dist : (rotary ? rot_dist : lin_dist);

  // moving phase ends on the switch-off window, a stop edge or loss of enable
  wire moving = (state == IPM_MOVE);
  wire arrive = moving && (remaining <= swoff);
  wire halt = moving && !arrive && (stop_e || !drive_en);
  wire keep_res = halt && relative; // [RL12]
  // a step seen in the stopping cycle has already been travelled, so it comes off the kept distance
  wire [W-1:0] next_remaining = (step_e && (remaining != '0)) ? (remaining - 1'b1) : remaining;
  wire drop_res = (launch && relative && !resume && res_valid && (res_dir != rel_dir))
               || (mode != prev_mode) || del_res; // [RL15]

  // next actual position, wrapping inside the rotary range
  wire [W-1:0] act_up = (rotary && (actual + 1'b1 >= axis_end)) ? '0 : (actual + 1'b1);
  wire [W-1:0] act_dn = (rotary && (actual == '0)) ? (axis_end - 1'b1) : (actual - 1'b1);
  wire [W-1:0] next_actual = step_e ? (o_drive.dir_pos ? act_up : act_dn) : actual;

  // read multiplexer; unmapped offsets read as zero
  wire [31:0] status = 32'({drive_en, synced, error, res_valid, o_drive.dir_pos, moving});
  wire [31:0] next_rd_data =
      (i_addr == `IPM_OFS_CTRL) ? ctrl :
      (i_addr == `IPM_OFS_CMD) ? 32'(cmd) :
      (i_addr == `IPM_OFS_ENTRY) ? 32'(entry) :
      (i_addr == `IPM_OFS_TBL_IDX) ? 32'(tbl_idx) :
      (i_addr == `IPM_OFS_TBL_DATA) ? 32'(dim_tbl[slot_of(tbl_idx)]) :
      (i_addr == `IPM_OFS_SWOFF) ? 32'(swoff) :
      (i_addr == `IPM_OFS_AXIS_END) ? 32'(axis_end) :
      (i_addr == `IPM_OFS_STATUS) ? status :
      (i_addr == `IPM_OFS_ACTUAL) ? 32'(actual) :
      (i_addr == `IPM_OFS_RESIDUAL) ? 32'(residual) : 32'h0000_0000;

  // software-written registers
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= `IPM_CTRL_RESET;
      cmd <= '0;
      entry <= `IPM_ENTRY_RESET;
      tbl_idx <= `IPM_ENTRY_RESET;
      swoff <= W'(`IPM_SWOFF_RESET);
      axis_end <= W'(`IPM_AXIS_END_RESET);
      prev_mode <= 2'h0;
      o_rd_data <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl <= i_wr_data;
      if (wr_cmd) cmd <= ipm_cmd_type'(i_wr_data[3:0]);
      if (wr_entry) entry <= i_wr_data[7:0];
      if (wr_idx) tbl_idx <= i_wr_data[7:0];
      if (wr_swoff) swoff <= i_wr_data[W-1:0];
      if (wr_end) axis_end <= i_wr_data[W-1:0];
      prev_mode <= mode;
      o_rd_data <= i_rd ? next_rd_data : 32'h0000_0000;
    end
  end

  // dimension table in flip-flops, one word per slot
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < SLOTS; i++) dim_tbl[i] <= '0;
    end else if (wr_data) begin
      dim_tbl[slot_of(tbl_idx)] <= i_wr_data[W-1:0];
    end
  end

  // move sequencer
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= IPM_IDLE;
      remaining <= '0;
      actual <= '0;
      o_drive <= '0;
    end else begin
      actual <= next_actual;
      case (state)
        IPM_IDLE: begin
          if (launch) begin
            state <= IPM_MOVE;
            remaining <= next_dist; // [RL1] [RL13]
            o_drive.dir_pos <= next_dir; // [RL8] [RL9] [RL10] [RL11]
            o_drive.run <= 1'b1;
          end
        end
        IPM_MOVE: begin
          if (arrive || halt) begin
            state <= IPM_IDLE;
            o_drive.run <= 1'b0;
          end else if (step_e && remaining != '0) begin
            remaining <= remaining - 1'b1;
          end
        end
        default: begin
          state <= IPM_IDLE;
          o_drive.run <= 1'b0;
        end
      endcase
    end
  end

  // residual store; a stop in the same cycle as a delete keeps the new residual
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_valid <= 1'b0;
      residual <= '0;
      res_entry <= 8'h00;
      res_dir <= 1'b0;
    end else if (keep_res) begin
      res_valid <= 1'b1; // [RL12]
      residual <= next_remaining;
      res_entry <= entry;
      res_dir <= o_drive.dir_pos;
    end else if (drop_res || (arrive && relative) || (launch && relative)) begin
      res_valid <= 1'b0; // [RL14] [RL15]
      residual <= '0;
    end else if (res_valid && !moving && step_e && (residual != '0)) begin
      // steps still in the synchroniser when the drive stopped were travelled too
      residual <= residual - 1'b1; // [RL12]
    end
  end

  // operating error: hardware set wins over a software clear
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      error <= 1'b0;
    end else if (reject) begin
      error <= 1'b1; // [RL17]
    end else if (wr_stat && i_wr_data[`IPM_ST_ERROR_BIT]) begin
      error <= 1'b0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_start_needs_all: assert property (
    $rose(o_drive.run) |-> $past(conds_ok && any_e)) else $error("move started without conditions"); // [RL2] [RL7]
  a_reject_error: assert property (
    reject |=> error && !o_drive.run) else $error("bad start not flagged or drive ran"); // [RL17]
  a_level_no_start: assert property (
    (state == IPM_IDLE) && !any_e |=> !o_drive.run) else $error("drive started without edge"); // [RL6]
  a_rel_direction: assert property (
    launch && relative |=> o_drive.dir_pos == $past(dirp_e)) else $error("relative direction wrong"); // [RL8]
  a_lin_abs_dir: assert property (
    launch && !relative && !rotary |=> o_drive.dir_pos == $past(dim_val >= actual)) else $error("linear dir"); // [RL9]
  a_rot_short_dir: assert property (
    launch && !relative && rotary && start_e |=> o_drive.dir_pos == $past(rot_short_up))
    else $error("rotary path not shortest"); // [RL10]
  a_rot_forced_dir: assert property (
    launch && !relative && rotary && !start_e |=> o_drive.dir_pos == $past(dirp_e))
    else $error("rotary forced direction ignored"); // [RL11]
  a_stop_keeps_rest: assert property (
    keep_res |=> res_valid && residual == $past(remaining) - $past(step_e && (remaining != '0)))
    else $error("residual not kept"); // [RL12]
  a_coast_trims: assert property (
    res_valid && !moving && step_e && !launch && !drop_res && (residual != '0)
    |=> residual == $past(residual) - 1'b1) else $error("coasting step not taken off residual"); // [RL12]
  a_resume_rest: assert property (
    launch && resume |=> remaining == $past(residual)) else $error("resume did not use residual"); // [RL13]
  a_delete_clears: assert property (
    del_res && !keep_res |=> !res_valid) else $error("delete left residual"); // [RL14]
  a_mode_clears: assert property (
    (mode != prev_mode) && !keep_res |=> !res_valid) else $error("mode change kept residual"); // [RL15]
endmodule
`default_nettype wire

// ### ipm_axis_model.sv
// drive and encoder stand-in for the positioning channel
`timescale 1ns/1ps
`default_nettype none
module ipm_axis_model (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire ipm_pkg::ipm_drive_type i_drive,
  input wire logic [3:0] i_half,
  output logic o_enc_step,
  output var int o_pos
);
  import ipm_pkg::*;
  logic [3:0] cnt;

  // the encoder line holds its last level while stopped, as a resting shaft does
  // i_half sets the speed, so the bench can make the axis prompt or slow
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 4'h0;
      o_enc_step <= 1'b0;
      o_pos <= 0;
    end else if (i_drive.run) begin
      cnt <= (cnt == i_half) ? 4'h0 : cnt + 4'h1;
      if (cnt == i_half) begin
        o_enc_step <= ~o_enc_step;
        if (!o_enc_step) o_pos <= o_pos + (i_drive.dir_pos ? 1 : -1);
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the incremental positioning channel
`timescale 1ns/1ps
`default_nettype none
`include "ipm_defines.svh"
module testbench;
  import ipm_pkg::*;
  logic clk, rstn, wr_s, rd_s, synced, drv_en, step;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, a0, a1;
  logic [3:0] half;
  ipm_drive_type drive;
  int pos, mismatches, n_compared;

  ipm_core ipm_core_i (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rd_data(rdata), .i_synced(synced), .i_drive_en(drv_en), .i_enc_step(step), .o_drive(drive));
  ipm_axis_model ipm_axis_model_i (.i_core_clk(clk), .i_rstn(rstn), .i_drive(drive), .i_half(half),
    .o_enc_step(step), .o_pos(pos));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // strobe is dropped at the edge that takes it, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a, v);
    chk(name, v, exp);
  endtask

  task automatic cmd(input logic [31:0] d);
    wr(`IPM_OFS_CMD, d);
  endtask

  task automatic ld(input logic [7:0] slot, input logic [31:0] val);
    wr(`IPM_OFS_TBL_IDX, {24'h0, slot});
    wr(`IPM_OFS_TBL_DATA, val);
  endtask

  // the drive answers one cycle after the command write; the check waits two
  task automatic go(input logic [31:0] d, input logic [1:0] exp);
    cmd(d);
    repeat (2) @(posedge clk);
    #1 chk("drive", {30'h0, drive}, {30'h0, exp});
  endtask

  // bounded wait; a hang shows up as a failed "move ended" check afterwards
  task automatic wait_idle;
    int n;
    n = 0;
    while (drive.run !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    #1 chk("move ended", {31'h0, drive.run}, 32'h0);
  endtask

  // start, let the axis travel a little, then stop it mid-way
  task automatic part(input logic [31:0] d);
    cmd(32'h0);
    cmd(d);
    repeat (30) @(posedge clk);
    cmd(d | 32'h8);
    repeat (12) @(posedge clk);
    cmd(32'h0);
  endtask

  task automatic t_reject;
    logic [31:0] c [4];
    c = '{32'h1A, 32'h19, 32'h1B, 32'h1B};
    rdchk("axis end", `IPM_OFS_AXIS_END, `IPM_AXIS_END_RESET);
    rdchk("unmapped", 8'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`IPM_OFS_CTRL, c[i]);
      synced <= (i != 2);
      drv_en <= (i != 3);
      repeat (4) @(posedge clk);
      cmd(32'h2);
      repeat (2) @(posedge clk);
      #1 chk("run blocked", {31'h0, drive.run}, 32'h0);
      rd(`IPM_OFS_STATUS, v);
      chk("error set", v & 32'h8, 32'h8);
      wr(`IPM_OFS_STATUS, 32'h8);
      cmd(32'h0);
    end
    rd(`IPM_OFS_STATUS, v);
    chk("error clear", v & 32'h8, 32'h0);
  endtask

  task automatic t_rel;
    @(posedge clk);
    synced <= 1'b1;
    drv_en <= 1'b1;
    wr(`IPM_OFS_CTRL, 32'h1B);
    wr(`IPM_OFS_SWOFF, 32'h0);
    wr(`IPM_OFS_ENTRY, 32'h0);
    ld(8'h0, 32'hA);
    go(32'h2, 2'b11);
    wait_idle;
    rdchk("rel plus", `IPM_OFS_ACTUAL, 32'hA);
    chk("axis pos", pos, 32'hA);
    cmd(32'h0);
    go(32'h4, 2'b10);
    wait_idle;
    rdchk("rel minus", `IPM_OFS_ACTUAL, 32'h0);
    repeat (20) @(posedge clk);
    #1 chk("level held", {31'h0, drive.run}, 32'h0);
    cmd(32'h0);
  endtask

  task automatic t_abs;
    wr(`IPM_OFS_CTRL, 32'h13);
    ld(`IPM_ENTRY_254, 32'h7);
    wr(`IPM_OFS_ENTRY, {24'h0, `IPM_ENTRY_254});
    go(32'h1, 2'b11);
    wait_idle;
    rdchk("abs up", `IPM_OFS_ACTUAL, 32'h7);
    cmd(32'h0);
    ld(8'h1, 32'h3);
    wr(`IPM_OFS_ENTRY, 32'h1);
    go(32'h1, 2'b10);
    wait_idle;
    rdchk("abs down", `IPM_OFS_ACTUAL, 32'h3);
    cmd(32'h0);
  endtask

  // from 3, target 350 is nearer going down; forced moves go the long way
  task automatic t_rot;
    wr(`IPM_OFS_CTRL, 32'h17);
    ld(`IPM_ENTRY_255, 32'h15E);
    wr(`IPM_OFS_SWOFF, 32'h0);
    wr(`IPM_OFS_ENTRY, {24'h0, `IPM_ENTRY_255});
    go(32'h1, 2'b10);
    wait_idle;
    rdchk("rot short", `IPM_OFS_ACTUAL, 32'h15E);
    cmd(32'h0);
    wr(`IPM_OFS_ENTRY, 32'h1);
    go(32'h4, 2'b10);
    cmd(32'hC);
    wait_idle;
    cmd(32'h0);
    ld(8'h2, 32'h154);
    wr(`IPM_OFS_ENTRY, 32'h2);
    go(32'h2, 2'b11);
    cmd(32'hA);
    wait_idle;
    cmd(32'h0);
  endtask

  task automatic t_res;
    half <= 4'h6;
    wr(`IPM_OFS_CTRL, 32'h1B);
    wr(`IPM_OFS_ENTRY, 32'h0);
    rd(`IPM_OFS_ACTUAL, a0);
    part(32'h2);
    rd(`IPM_OFS_ACTUAL, a1);
    rdchk("residual", `IPM_OFS_RESIDUAL, 32'hA - (a1 - a0));
    rd(`IPM_OFS_STATUS, v);
    chk("resid flag", v & 32'h4, 32'h4);
    go(32'h2, 2'b11);
    wait_idle;
    rdchk("resume end", `IPM_OFS_ACTUAL, a0 + 32'hA);
    part(32'h2);
    cmd(32'h100);
    rd(`IPM_OFS_STATUS, v);
    chk("deleted", v & 32'h4, 32'h0);
    part(32'h2);
    wr(`IPM_OFS_CTRL, 32'h2B);
    wr(`IPM_OFS_CTRL, 32'h1B);
    rd(`IPM_OFS_STATUS, v);
    chk("mode change", v & 32'h4, 32'h0);
    part(32'h2);
    rd(`IPM_OFS_ACTUAL, a1);
    go(32'h4, 2'b10);
    wait_idle;
    rdchk("reverse full", `IPM_OFS_ACTUAL, a1 - 32'hA);
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    synced = 1'b0;
    drv_en = 1'b0;
    half = 4'h2;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reject;
    t_rel;
    t_abs;
    t_rot;
    t_res;
    report_and_stop;
  end

  // all scenarios fit well inside 40000 cycles
  initial begin
    #1000000;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
